// *** core/nmr_freq_counter.sv ***
// Functional notes
// R1: 8.5-digit count, read as field in 0.1 uT or frequency in 1 Hz steps.
// R2: gate 0.93949464 s proton, 1.5300599 s deuteron, 1.0000000 s frequency.
// R3: proton field readings count the input divided by four.
// R4: deuteron field and frequency readings count the input undivided.
// R5: the time-base makes both the display load strobe and the counter reset.
// R6: coarse gate lengths are counted down in 10 us ticks of a 100 kHz reference.
// R7: a fine interval extends the coarse gate and trims it by +/-40 ppm.
// R8: one fine interval per mode, three in all; only the active one runs.
// R9: gate end gives load strobe, then counter reset, then the next gate.
`timescale 1ns/1ps
`include "fc_params.svh"

module nmr_freq_counter
  import fc_pkg::*;
#(
  parameter int P_REF_DIV = `REF_DIV,
  parameter int P_COARSE_P = `COARSE(`GATE_P_NS),
  parameter int P_COARSE_D = `COARSE(`GATE_D_NS),
  parameter int P_COARSE_F = `COARSE(`GATE_F_NS)
) (
  input wire logic I_CLK_SYS,           // 50 MHz system clock
  input wire logic I_RESETN,            // async reset, active low
  input wire logic i_ce,                // clock enable, freezes all
  input wire logic i_rf,                // probe rf, synchronous level
  input wire logic i_field_disp,        // 1 field display, 0 frequency
  input wire logic i_deuteron,          // 1 deuteron probe, 0 proton
  input wire cal_s i_cal,               // fine lengths per mode, cycles
  output disp_s o_disp,                 // display register
  output logic o_load,                  // display transfer strobe
  output logic o_cnt_reset,             // counter reset strobe
  output logic o_gate,                  // gate open
  output mode_e o_mode                  // mode of the running gate
);
  localparam int FINE_LO_P = `FINE_NOM(`GATE_P_NS) - `FINE_SPAN(`GATE_P_NS);
  localparam int FINE_HI_P = `FINE_NOM(`GATE_P_NS) + `FINE_SPAN(`GATE_P_NS);
  localparam int FINE_LO_D = `FINE_NOM(`GATE_D_NS) - `FINE_SPAN(`GATE_D_NS);
  localparam int FINE_HI_D = `FINE_NOM(`GATE_D_NS) + `FINE_SPAN(`GATE_D_NS);
  localparam int FINE_LO_F = `FINE_NOM(`GATE_F_NS) - `FINE_SPAN(`GATE_F_NS);
  localparam int FINE_HI_F = `FINE_NOM(`GATE_F_NS) + `FINE_SPAN(`GATE_F_NS);

  state_e state_r;
  mode_e mode_r;
  mode_e mode_sel;
  logic [`DIV_W-1:0] div_r;
  logic tick;
  logic [`COARSE_W-1:0] coarse_r;
  logic [`COARSE_W-1:0] coarse_sel;
  logic [`CNT_W-1:0] cnt_r;
  logic ovf_r;
  logic [`PRE_W-1:0] pre_r;
  logic rf_d_r;
  logic rf_rise;
  logic counting;
  logic cnt_en;
  logic fine_go;
  logic [2:0] fine_start;
  logic [2:0] fine_busy;
  logic [2:0] fine_done;
  logic [`FINE_W-1:0] fine_len [3];

  always_comb begin
    if (!i_field_disp) begin
      mode_sel = MODE_FREQ;
      coarse_sel = `COARSE_W'(P_COARSE_F);
    end else if (i_deuteron) begin
      mode_sel = MODE_DEUT;
      coarse_sel = `COARSE_W'(P_COARSE_D);
    end else begin
      mode_sel = MODE_PROTON;
      coarse_sel = `COARSE_W'(P_COARSE_P);
    end
  end

  // calibration is clamped so a bad trim can never leave the 40 ppm window
  function automatic logic [`FINE_W-1:0] clamp(
    input logic [`FINE_W-1:0] v, input int lo, input int hi);
    if (int'(v) < lo) return `FINE_W'(lo);
    if (int'(v) > hi) return `FINE_W'(hi);
    return v;
  endfunction

  always_comb begin
    fine_len[0] = clamp(i_cal.proton, FINE_LO_P, FINE_HI_P); // [R7]
    fine_len[1] = clamp(i_cal.deut, FINE_LO_D, FINE_HI_D); // [R7]
    fine_len[2] = clamp(i_cal.freq, FINE_LO_F, FINE_HI_F); // [R7]
  end

  // 100 kHz reference tick, restarted with each gate so phase is exact
  assign tick = (div_r == `DIV_W'(P_REF_DIV - 1));

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      div_r <= '0;
    end else if (i_ce) begin
      if (state_r == ST_CLR || tick) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + `DIV_W'h1;
      end
    end
  end

  assign fine_go = (state_r == ST_GATE) && tick && (coarse_r == `COARSE_W'h1);

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_r <= ST_CLR;
      mode_r <= MODE_PROTON;
      coarse_r <= '0;
    end else if (i_ce) begin
      case (state_r)
        ST_CLR: begin
          mode_r <= mode_sel; // [R2]
          coarse_r <= coarse_sel; // [R2]
          state_r <= ST_GATE; // [R9]
        end
        ST_GATE: begin
          if (tick) begin
            coarse_r <= coarse_r - `COARSE_W'h1; // [R6]
          end
          if (fine_go) begin
            state_r <= ST_FINE; // [R7]
          end
        end
        ST_FINE: begin
          if (|fine_done) begin
            state_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          state_r <= ST_CLR; // [R9]
        end
        default: begin
          state_r <= ST_CLR;
        end
      endcase
    end
  end

  // one interval per mode; only the active mode's one is fired
  for (genvar k = 0; k < 3; k++) begin : g_fine
    assign fine_start[k] = fine_go && (mode_r == mode_e'(k)); // [R8]
    fine_oneshot u_fine (
      .i_clk(I_CLK_SYS),
      .i_resetn(I_RESETN),
      .i_ce(i_ce),
      .i_start(fine_start[k]),
      .i_len(fine_len[k]),
      .o_busy(fine_busy[k]),
      .o_done(fine_done[k])
    );
  end

  assign rf_rise = i_rf && !rf_d_r;
  assign counting = (state_r == ST_GATE) || (state_r == ST_FINE);
  assign cnt_en = counting && rf_rise &&
    (mode_r != MODE_PROTON || pre_r == `PRE_W'(`PRESCALE - 1)); // [R3] [R4]

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rf_d_r <= 1'b0;
      pre_r <= '0;
    end else if (i_ce) begin
      rf_d_r <= i_rf;
      if (state_r == ST_CLR) begin
        pre_r <= '0;
      end else if (counting && rf_rise && mode_r == MODE_PROTON) begin
        pre_r <= pre_r + `PRE_W'h1; // [R3]
      end
    end
  end

  // saturates at 199999999, the largest eight-and-a-half digit value
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else if (i_ce) begin
      if (state_r == ST_CLR) begin
        cnt_r <= '0; // [R5]
        ovf_r <= 1'b0;
      end else if (cnt_en) begin
        if (cnt_r == `CNT_W'(`CNT_MAX)) begin
          ovf_r <= 1'b1; // [R1]
        end else begin
          cnt_r <= cnt_r + `CNT_W'h1; // [R1]
        end
      end
    end
  end

  // display holds between transfers so the reading stays steady
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      o_disp <= '0;
      o_load <= 1'b0;
      o_cnt_reset <= 1'b0;
      o_gate <= 1'b0;
      o_mode <= MODE_PROTON;
    end else if (i_ce) begin
      o_load <= (state_r == ST_XFER); // [R5] [R9]
      o_cnt_reset <= (state_r == ST_CLR); // [R5] [R9]
      o_gate <= counting;
      o_mode <= mode_r;
      if (state_r == ST_XFER) begin
        o_disp.value <= cnt_r; // [R1]
        o_disp.overflow <= ovf_r;
      end
    end
  end

  logic [`COARSE_W-1:0] past_coarse_r;
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      past_coarse_r <= '0;
    end else if (i_ce) begin
      past_coarse_r <= coarse_r;
    end
  end

  property p_load_order;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    o_load && i_ce |=> o_cnt_reset && !o_load;
  endproperty
  a_load_order: assert property (p_load_order) // [R9]
    else $error("counter reset did not follow load strobe");

  property p_reset_then_gate;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    o_cnt_reset && i_ce |=> o_gate && !o_load;
  endproperty
  a_reset_then_gate: assert property (p_reset_then_gate) // [R9]
    else $error("gate did not open after counter reset");

  property p_load_value;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    o_load |-> o_disp.value == cnt_r && state_r == ST_CLR;
  endproperty
  a_load_value: assert property (p_load_value) // [R1]
    else $error("display does not hold the final count");

  property p_gate_start;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    state_r == ST_CLR && i_ce |=> coarse_r == $past(coarse_sel);
  endproperty
  a_gate_start: assert property (p_gate_start) // [R2]
    else $error("gate loaded with the wrong coarse length");

  property p_coarse_tick;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    state_r == ST_GATE && $past(state_r) == ST_GATE && coarse_r != past_coarse_r
      |-> $past(tick) && coarse_r == past_coarse_r - `COARSE_W'h1;
  endproperty
  a_coarse_tick: assert property (p_coarse_tick) // [R6]
    else $error("coarse count moved off a reference tick");

  property p_fine_mode;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    |fine_busy |-> fine_busy[mode_r] && $onehot(fine_busy);
  endproperty
  a_fine_mode: assert property (p_fine_mode) // [R8]
    else $error("fine interval of another mode is running");

  property p_fine_range;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    int'(fine_len[0]) >= FINE_LO_P && int'(fine_len[0]) <= FINE_HI_P &&
    int'(fine_len[1]) >= FINE_LO_D && int'(fine_len[1]) <= FINE_HI_D &&
    int'(fine_len[2]) >= FINE_LO_F && int'(fine_len[2]) <= FINE_HI_F;
  endproperty
  a_fine_range: assert property (p_fine_range) // [R7]
    else $error("fine interval outside the trim window");

  property p_prescale;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    cnt_en && mode_r == MODE_PROTON |-> pre_r == `PRE_W'(`PRESCALE - 1);
  endproperty
  a_prescale: assert property (p_prescale) // [R3]
    else $error("proton count taken off the prescale wrap");

  property p_direct;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    i_ce && counting && rf_rise && mode_r != MODE_PROTON && !ovf_r &&
      cnt_r != `CNT_W'(`CNT_MAX) |=> cnt_r == $past(cnt_r) + `CNT_W'h1;
  endproperty
  a_direct: assert property (p_direct) // [R4]
    else $error("direct count missed an input edge");

  c_proton: cover property (@(posedge I_CLK_SYS)
    o_load && o_mode == MODE_PROTON);
  c_deut: cover property (@(posedge I_CLK_SYS)
    o_load && o_mode == MODE_DEUT);
  c_freq: cover property (@(posedge I_CLK_SYS)
    o_load && o_mode == MODE_FREQ);
  c_ovf: cover property (@(posedge I_CLK_SYS)
    o_load && o_disp.overflow);
endmodule // nmr_freq_counter

// *** pkg/fc_params.svh ***
`ifndef FC_PARAMS_SVH
`define FC_PARAMS_SVH

// reference tick and system clock periods
`define TICK_NS 10000
`define SYS_NS 20
`define REF_DIV (`TICK_NS / `SYS_NS)

// gate lengths in ns
`define GATE_P_NS 939494640
`define GATE_D_NS 1530059900
`define GATE_F_NS 1000000000

// fine adjust range is +/-40 ppm, i.e. gate / 25000
`define TRIM_PPM 40
`define PPM_DIV (1000000 / `TRIM_PPM)

// coarse part stops 40 ppm short; fine part fills the rest
`define COARSE(g) (((g) - (g) / `PPM_DIV) / `TICK_NS)
`define FINE_NOM(g) (((g) - `COARSE(g) * `TICK_NS) / `SYS_NS)
`define FINE_SPAN(g) (((g) / `PPM_DIV) / `SYS_NS)

`define PRESCALE 4
`define PRE_W 2
`define CNT_W 28
`define CNT_MAX 199999999
`define FINE_W 16
`define COARSE_W 18
`define DIV_W 12

`endif

// *** pkg/fc_pkg.sv ***
`include "fc_params.svh"

package fc_pkg;
  typedef enum logic [1:0] {
    MODE_PROTON = 2'b00,
    MODE_DEUT = 2'b01,
    MODE_FREQ = 2'b10
  } mode_e;

  typedef enum logic [1:0] {
    ST_CLR = 2'b00,
    ST_GATE = 2'b01,
    ST_FINE = 2'b10,
    ST_XFER = 2'b11
  } state_e;

  typedef struct packed {
    logic [`FINE_W-1:0] freq;
    logic [`FINE_W-1:0] deut;
    logic [`FINE_W-1:0] proton;
  } cal_s;

  typedef struct packed {
    logic overflow;
    logic [`CNT_W-1:0] value;
  } disp_s;
endpackage

// *** core/fine_oneshot.sv ***
`timescale 1ns/1ps
`include "fc_params.svh"

module fine_oneshot (
  input wire logic i_clk,                   // system clock
  input wire logic i_resetn,                // async reset, active low
  input wire logic i_ce,                    // clock enable
  input wire logic i_start,                 // one-cycle start pulse
  input wire logic [`FINE_W-1:0] i_len,     // length in clock cycles
  output logic o_busy,                      // interval running
  output logic o_done                       // one-cycle end pulse
);
  logic [`FINE_W-1:0] left_r;
  logic run_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      left_r <= '0;
      run_r <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (i_start) begin
        left_r <= i_len;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (left_r <= `FINE_W'h1) begin
          run_r <= 1'b0;
          left_r <= '0;
          o_done <= 1'b1;
        end else begin
          left_r <= left_r - `FINE_W'h1;
        end
      end
    end
  end

  assign o_busy = run_r;
endmodule // fine_oneshot

// *** sim/rf_source.sv ***
`timescale 1ns/1ps

module rf_source #(
  parameter int P_HALF = 2
) (
  input wire logic i_clk,  // system clock
  input wire logic i_en,   // run the probe oscillator
  output logic o_rf        // probe rf level
);
  int cnt;

  initial begin
    o_rf = 1'b0;
    cnt = 0;
  end

  // a level of at least one cycle per phase keeps every edge countable
  always @(posedge i_clk) begin
    if (i_en) begin
      if (cnt == P_HALF - 1) begin
        cnt <= 0;
        o_rf <= ~o_rf;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // rf_source

// *** sim/testbench.sv ***
`timescale 1ns/1ps

module testbench;
  import fc_pkg::*;
  localparam int DIV = 4;
  localparam int CRS = 3;
  logic I_CLK_SYS, I_RESETN, rf, fld, deut;
  cal_s cal;
  disp_s disp;
  logic load, cnt_reset, gate, ce;
  mode_e mode;
  int bad_count, num_checks, cycles;

  nmr_freq_counter #(.P_REF_DIV(DIV), .P_COARSE_P(CRS), .P_COARSE_D(CRS),
      .P_COARSE_F(CRS)) nmr_freq_counter_i (
    .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .i_ce(ce), .i_rf(rf),
    .i_field_disp(fld), .i_deuteron(deut), .i_cal(cal), .o_disp(disp),
    .o_load(load), .o_cnt_reset(cnt_reset), .o_gate(gate), .o_mode(mode));

  // period of four system cycles, well under the countable limit
  rf_source #(.P_HALF(2)) rf_source_i (
    .i_clk(I_CLK_SYS), .i_en(1'b1), .o_rf(rf));

  initial begin
    I_CLK_SYS = 1'b0;
    forever #10 I_CLK_SYS = ~I_CLK_SYS;
  end

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge I_CLK_SYS) begin
    cycles++;
    if (cycles == 100000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic tick();
    @(posedge I_CLK_SYS);
    #1;
  endtask

  task automatic wait_load();
    int n;
    n = 0;
    while (load !== 1'b1 && n < 9000) begin
      n++;
      tick();
    end
    check("load seen", load, 1'b1);
  endtask

  task automatic t_reset();
    #1;
    check("load in reset", load, 1'b0);
    check("gate in reset", gate, 1'b0);
    check("mode in reset", mode, MODE_PROTON);
    check("disp in reset", disp, '0);
    @(posedge I_CLK_SYS);
    I_RESETN <= 1'b1;
    tick();
    check("reset after release", cnt_reset, 1'b1);
    tick();
    check("gate after release", gate, 1'b1);
  endtask

  // clock enable low must hold gate, display, counter reset and mode mid-gate
  task automatic t_freeze();
    disp_s held;
    wait_load();
    tick();
    tick();
    held = disp;
    ce <= 1'b0;
    repeat (20) tick();
    check("gate frozen", gate, 1'b1);
    check("disp frozen", disp, held);
    check("reset frozen", cnt_reset, 1'b0);
    check("mode frozen", mode, MODE_PROTON);
    ce <= 1'b1;
    wait_load();
  endtask

  // one gate in the new mode: order, length and count at its end
  task automatic t_gate(input logic f, input logic d, input mode_e m,
      input int fine, input int pre);
    int n, len, lo, hi;
    fld <= f;
    deut <= d;
    wait_load();
    tick();
    wait_load();
    check("gate at load", gate, 1'b0);
    tick();
    check("reset after load", cnt_reset, 1'b1);
    check("load one cycle", load, 1'b0);
    tick();
    check("gate after reset", gate, 1'b1);
    check("mode", mode, m);
    len = CRS * DIV + fine + 1;
    n = 0;
    while (gate === 1'b1 && n < 9000) begin
      n++;
      tick();
    end
    check("gate length", n, len);
    wait_load();
    lo = len / (4 * pre) - 1;
    hi = len / (4 * pre) + 1;
    check("count in range", (disp.value >= lo && disp.value <= hi),
        1'b1);
    check("overflow", disp.overflow, 1'b0);
  endtask

  initial begin
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    I_RESETN = 1'b0;
    ce = 1'b1;
    fld = 1'b1;
    deut = 1'b0;
    cal = '{freq: 16'h07d0, deut: 16'h0da7, proton: 16'h08b8};
    repeat (5) @(posedge I_CLK_SYS);
    t_reset();
    t_gate(1'b1, 1'b0, MODE_PROTON, 2232, 4);
    t_gate(1'b1, 1'b1, MODE_DEUT, 3495, 1);
    t_gate(1'b0, 1'b1, MODE_FREQ, 2000, 1);
    // trim beyond the window lands on its bound
    cal.freq <= 16'h1004;
    t_gate(1'b0, 1'b0, MODE_FREQ, 4000, 1);
    cal.proton <= 16'h0000;
    t_gate(1'b1, 1'b0, MODE_PROTON, 354, 4);
    t_freeze();
    report_and_stop();
  end
endmodule // testbench
